// [abrfmt_buffer.v]
// result formatter and fill-mode controller with an AXI4-Lite register slave
`include "abrfmt_regs.vh"
`default_nettype none
// Overview of operation
// R1: result memory holds one 16-bit word per channel, even count, sixteen words.
// R2: conversions-per-interrupt field value plus one gives the group size, 1 to 32.
// R3: after every interrupt writing restarts at the first word of the active region.
// R4: control-two bit 11 picks fill mode: zero sequential, one channel indexed.
// R5: sequential mode writes successive words, first one first, wrapping after the last.
// R6: split bit 1 halves memory; halves alternate at each interrupt event.
// R7: after split is set the first group goes to the lower half.
// R8: with split clear the whole memory serves every sequence.
// R9: software keeps group size within half the memory while split is on.
// R10: read-only bit 7 of control two shows the half being filled.
// R11: channel-indexed mode writes each result to the word of its channel.
// R12: a repeat conversion on a channel overwrites its word before the interrupt.
// R13: format field bits 9:8 of control one picks one of four 16-bit formats.
// R14: integer format right-justifies with zero upper bits.
// R15: signed integer inverts the msb and sign-extends, right-justified.
// R16: fractional format left-justifies with zeros below.
// R17: signed fractional inverts the msb and left-justifies with zeros below.
// R18: in 10-bit resolution fractional formats append six zero bits.
// R19: filling only happens when compare mode bits 3:2 of control five are zero.
// R20: the interrupt flag rises after each completed group of conversions.
// R21: switching the converter off abandons a conversion; memory keeps old data.
// R22: fill-half flips with the half switch and clears when split is enabled.
module abrfmt_buffer (
	input wire sys_clk_i,
	input wire rst_i,
	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// ****************************************************************
	// converter core side
	// ****************************************************************
	input wire conv_done_i,
	input wire [11:0] conv_data_i,
	input wire [4:0] conv_chan_i,
	output wire converter_on_o,
	output wire conversion_interrupt_flag_o,
	output wire fill_half_status_o
);
	localparam SEL_NONE = 3'd0;
	localparam SEL_ONE = 3'd1;
	localparam SEL_TWO = 3'd2;
	localparam SEL_FIVE = 3'd3;
	localparam SEL_STAT = 3'd4;
	localparam SEL_RES = 3'd5;

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// address decode shared by the read and write channels
	function [2:0] decode_sel;
		input [7:0] addr;
		begin
			if (addr[7:6] == 2'b01 && addr[1:0] == 2'b00) begin
				decode_sel = SEL_RES;
			end else if (addr == `ABRFMT_OFS_CTRL_ONE) begin
				decode_sel = SEL_ONE;
			end else if (addr == `ABRFMT_OFS_CTRL_TWO) begin
				decode_sel = SEL_TWO;
			end else if (addr == `ABRFMT_OFS_CTRL_FIVE) begin
				decode_sel = SEL_FIVE;
			end else if (addr == `ABRFMT_OFS_STATUS) begin
				decode_sel = SEL_STAT;
			end else begin
				decode_sel = SEL_NONE;
			end
		end
	endfunction

	// raw code to stored word; 10-bit codes sit in the low bits of raw
	function [15:0] format_word;
		input [1:0] form;
		input res10;
		input [11:0] raw;
		begin
			case (form)
				`ABRFMT_FMT_INT: begin
					format_word = res10 ? {6'h00, raw[9:0]} : {4'h0, raw}; // R14
				end
				`ABRFMT_FMT_SINT: begin
					format_word = res10 ? {{7{~raw[9]}}, raw[8:0]} :
						{{5{~raw[11]}}, raw[10:0]}; // R15
				end
				`ABRFMT_FMT_FRAC: begin
					format_word = res10 ? {raw[9:0], 6'h00} : {raw, 4'h0}; // R16 R18
				end
				`ABRFMT_FMT_SFRAC: begin
					format_word = res10 ? {~raw[9], raw[8:0], 6'h00} :
						{~raw[11], raw[10:0], 4'h0}; // R17 R18
				end
				default: begin
					format_word = 16'h0000;
				end
			endcase
		end
	endfunction

	// ****************************************************************
	// control state
	// ****************************************************************
	reg [1:0] form_q;
	reg res10_q;
	reg on_q;
	reg [4:0] smpi_q;
	reg split_q;
	reg chidx_q;
	reg [1:0] cmp_q;
	reg iflag_q;
	reg half_q;
	reg [3:0] ptr_q;
	reg [4:0] count_q;

	// write channel holding registers
	reg aw_hold_q;
	reg [7:0] awaddr_q;
	reg w_hold_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	// read channel
	reg rd_stage_q;
	reg [2:0] rsel_q;

	wire do_write;
	wire [2:0] wsel;
	wire ar_take;
	wire [2:0] asel;
	wire wr_one;
	wire wr_two;
	wire wr_five;
	wire wr_stat;
	wire split_rise;
	wire accept;
	wire group_end;
	wire [3:0] region_last;
	wire [3:0] fifo_addr;
	wire chan_ok;
	wire ram_we;
	wire [3:0] ram_waddr;
	wire [15:0] ram_wdata;
	wire [15:0] ram_rdata;
	reg [31:0] reg_rdata;

	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wsel = decode_sel(awaddr_q);
	assign s_axi_arready = !rd_stage_q && !s_axi_rvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign asel = decode_sel(s_axi_araddr);

	// byte lanes gate each field by the lane it lives in
	assign wr_one = do_write && wsel == SEL_ONE && wstrb_q[1];
	assign wr_two = do_write && wsel == SEL_TWO;
	assign wr_five = do_write && wsel == SEL_FIVE && wstrb_q[0];
	assign wr_stat = do_write && wsel == SEL_STAT && wstrb_q[0];
	assign split_rise = wr_two && wstrb_q[0] && wdata_q[`ABRFMT_SPLIT_BIT] && !split_q;

	// ****************************************************************
	// fill control
	// ****************************************************************
	// a done pulse is dropped while off, so memory keeps its old word
	assign accept = conv_done_i && on_q && cmp_q == `ABRFMT_CMP_LEGACY; // R19 R21
	assign group_end = accept && count_q == smpi_q; // R2 R20
	assign region_last = split_q ? `ABRFMT_LAST_HALF_WORD : `ABRFMT_LAST_WORD; // R6 R8
	// upper half is the lower index plus eight when split is on
	assign fifo_addr = (split_q && half_q) ? (ptr_q | `ABRFMT_HALF_WORDS) : ptr_q; // R6
	// in channel-indexed mode, channels beyond the memory have no word and are not stored
	assign chan_ok = conv_chan_i < `ABRFMT_WORDS; // R1
	assign ram_we = accept && (!chidx_q || chan_ok);
	assign ram_waddr = chidx_q ? conv_chan_i[3:0] : fifo_addr; // R4 R11 R12
	assign ram_wdata = format_word(form_q, res10_q, conv_data_i); // R13

	// pointer, group counter and active half
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_q <= 4'h0;
			count_q <= 5'h00;
			half_q <= 1'b0;
		end else if (split_rise || !on_q) begin
			// fresh start: first word of the lower half
			ptr_q <= 4'h0; // R5 R7
			count_q <= 5'h00;
			half_q <= 1'b0; // R22
		end else if (accept) begin
			if (group_end) begin
				ptr_q <= 4'h0; // R3
				count_q <= 5'h00;
				half_q <= split_q ? ~half_q : 1'b0; // R6 R22
			end else begin
				ptr_q <= (ptr_q == region_last) ? 4'h0 : ptr_q + 4'h1; // R5
				count_q <= count_q + 5'h01;
			end
		end
	end

	// interrupt flag: hardware set wins over software clear
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			iflag_q <= 1'b0;
		end else if (group_end) begin
			iflag_q <= 1'b1; // R20
		end else if (wr_stat && wdata_q[`ABRFMT_IFLAG_BIT]) begin
			iflag_q <= 1'b0;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			form_q <= `ABRFMT_RST_FORM;
			res10_q <= 1'b0;
			on_q <= 1'b0;
			smpi_q <= `ABRFMT_RST_SMPI;
			split_q <= 1'b0;
			chidx_q <= 1'b0;
			cmp_q <= `ABRFMT_RST_CMP;
		end else begin
			if (wr_one) begin
				form_q <= wdata_q[`ABRFMT_FORM_HI:`ABRFMT_FORM_LO]; // R13
				res10_q <= wdata_q[`ABRFMT_RES10_BIT];
				on_q <= wdata_q[`ABRFMT_ON_BIT];
			end
			if (wr_two && wstrb_q[0]) begin
				smpi_q <= wdata_q[`ABRFMT_SMPI_HI:`ABRFMT_SMPI_LO]; // R2
				split_q <= wdata_q[`ABRFMT_SPLIT_BIT]; // R6
			end
			if (wr_two && wstrb_q[1]) begin
				chidx_q <= wdata_q[`ABRFMT_CHIDX_BIT]; // R4
			end
			if (wr_five) begin
				cmp_q <= wdata_q[`ABRFMT_CMP_HI:`ABRFMT_CMP_LO]; // R19
			end
		end
	end

	// ****************************************************************
	// AXI write channel
	// ****************************************************************
	// address and data may arrive in either order; response after both
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_hold_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ABRFMT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// result words are read-only; unmapped answers slave error
				s_axi_bresp <= (wsel == SEL_NONE || wsel == SEL_RES) ?
					`ABRFMT_RESP_SLVERR : `ABRFMT_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// AXI read channel
	// ****************************************************************
	// register view; fill-half reads zero while split is off
	always @* begin
		reg_rdata = 32'h00000000;
		case (rsel_q)
			SEL_ONE: begin
				reg_rdata[`ABRFMT_FORM_HI:`ABRFMT_FORM_LO] = form_q;
				reg_rdata[`ABRFMT_RES10_BIT] = res10_q;
				reg_rdata[`ABRFMT_ON_BIT] = on_q;
			end
			SEL_TWO: begin
				reg_rdata[`ABRFMT_SMPI_HI:`ABRFMT_SMPI_LO] = smpi_q;
				reg_rdata[`ABRFMT_SPLIT_BIT] = split_q;
				reg_rdata[`ABRFMT_HALF_BIT] = half_q && split_q; // R10
				reg_rdata[`ABRFMT_CHIDX_BIT] = chidx_q;
			end
			SEL_FIVE: begin
				reg_rdata[`ABRFMT_CMP_HI:`ABRFMT_CMP_LO] = cmp_q;
			end
			SEL_STAT: begin
				reg_rdata[`ABRFMT_IFLAG_BIT] = iflag_q;
			end
			SEL_RES: begin
				reg_rdata[15:0] = ram_rdata;
			end
			default: begin
				reg_rdata = 32'h00000000;
			end
		endcase
	end

	// two-stage read: memory access, then registered answer
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_stage_q <= 1'b0;
			rsel_q <= SEL_NONE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ABRFMT_RESP_OKAY;
		end else begin
			if (ar_take) begin
				rd_stage_q <= 1'b1;
				rsel_q <= asel;
			end else if (rd_stage_q) begin
				rd_stage_q <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= reg_rdata;
				s_axi_rresp <= (rsel_q == SEL_NONE) ?
					`ABRFMT_RESP_SLVERR : `ABRFMT_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// result memory and outputs
	// ****************************************************************
	abrfmt_result_ram u_ram (
		.sys_clk_i(sys_clk_i),
		.wr_en_i(ram_we),
		.wr_addr_i(ram_waddr),
		.wr_data_i(ram_wdata),
		.rd_en_i(ar_take),
		.rd_addr_i(s_axi_araddr[5:2]),
		.rd_data_o(ram_rdata)
	); // R1

	assign converter_on_o = on_q;
	assign conversion_interrupt_flag_o = iflag_q;
	assign fill_half_status_o = half_q && split_q; // R10
endmodule
`default_nettype wire

// [abrfmt_regs.vh]
// register map, field positions, reset values and sizes of the result buffer formatter
`ifndef ABRFMT_REGS_VH
`define ABRFMT_REGS_VH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define ABRFMT_OFS_CTRL_ONE 8'h00
`define ABRFMT_OFS_CTRL_TWO 8'h04
`define ABRFMT_OFS_CTRL_FIVE 8'h08
`define ABRFMT_OFS_STATUS 8'h0C
`define ABRFMT_OFS_RESULT_BASE 8'h40
// ****************************************************************
// field positions
// ****************************************************************
`define ABRFMT_FORM_LO 8
`define ABRFMT_FORM_HI 9
`define ABRFMT_RES10_BIT 10
`define ABRFMT_ON_BIT 15
`define ABRFMT_SPLIT_BIT 1
`define ABRFMT_SMPI_LO 2
`define ABRFMT_SMPI_HI 6
`define ABRFMT_HALF_BIT 7
`define ABRFMT_CHIDX_BIT 11
`define ABRFMT_CMP_LO 2
`define ABRFMT_CMP_HI 3
`define ABRFMT_IFLAG_BIT 0
// ****************************************************************
// reset values, encodings and sizes
// ****************************************************************
`define ABRFMT_RST_FORM 2'h0
`define ABRFMT_RST_SMPI 5'h00
`define ABRFMT_RST_CMP 2'h0
`define ABRFMT_CMP_LEGACY 2'h0
`define ABRFMT_FMT_INT 2'h0
`define ABRFMT_FMT_SINT 2'h1
`define ABRFMT_FMT_FRAC 2'h2
`define ABRFMT_FMT_SFRAC 2'h3
`define ABRFMT_WORDS 5'h10
`define ABRFMT_AW 4
`define ABRFMT_HALF_WORDS 4'h8
`define ABRFMT_LAST_WORD 4'hF
`define ABRFMT_LAST_HALF_WORD 4'h7
`define ABRFMT_RESP_OKAY 2'h0
`define ABRFMT_RESP_SLVERR 2'h2
`endif

// [abrfmt_result_ram.v]
// result memory: one 16-bit word per channel, registered read data
`default_nettype none
module abrfmt_result_ram (
	input wire sys_clk_i,
	input wire wr_en_i,
	input wire [3:0] wr_addr_i,
	input wire [15:0] wr_data_i,
	input wire rd_en_i,
	input wire [3:0] rd_addr_i,
	output reg [15:0] rd_data_o
);
	reg [15:0] mem [0:15];

	// contents need no reset; software reads what was last stored
	always @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

// [abrfmt_chk.sv]
// port checker for the result buffer formatter
`default_nettype none
module abrfmt_chk (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic conv_done_i,
	input wire logic converter_on_o,
	input wire logic conversion_interrupt_flag_o,
	input wire logic fill_half_status_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// answers stand until taken; a pending answer blocks new writes
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read answer late");
	// flag only clears by a register write, only rises on a taken result
	flag_clear_a: assert property ($fell(conversion_interrupt_flag_o) |-> $rose(s_axi_bvalid))
		else $error("flag cleared without write");
	flag_rise_a: assert property ($rose(conversion_interrupt_flag_o) |->
		$past(conv_done_i) && $past(converter_on_o)) else $error("flag rose without result");
	half_rise_a: assert property ($rose(fill_half_status_o) |->
		$past(conv_done_i) && conversion_interrupt_flag_o) else $error("half moved off group end");
	half_off_a: assert property (!converter_on_o && $past(converter_on_o) == 1'b0 |->
		!fill_half_status_o) else $error("half set while off");
	cover property ($rose(conversion_interrupt_flag_o));
	cover property ($rose(fill_half_status_o));
	cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind abrfmt_buffer abrfmt_chk CHK (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_done_i(conv_done_i), .converter_on_o(converter_on_o),
	.conversion_interrupt_flag_o(conversion_interrupt_flag_o),
	.fill_half_status_o(fill_half_status_o));
`default_nettype wire

// [abrfmt_conv_model.sv]
// converter core stand-in: one result pulse per call
`default_nettype none
module abrfmt_conv_model (
	input wire logic sys_clk_i,
	output logic conv_done_o,
	output logic [11:0] conv_data_o,
	output logic [4:0] conv_chan_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle values at time zero
	initial begin
		conv_done_o = 1'h0;
		conv_data_o = 12'h000;
		conv_chan_o = 5'h00;
	end
	// scramble the bus after the pulse so stale data is never trusted
	task automatic conv(input logic [4:0] ch, input logic [11:0] raw);
		begin
			@(posedge sys_clk_i);
			conv_done_o <= 1'h1;
			conv_data_o <= raw;
			conv_chan_o <= ch;
			@(posedge sys_clk_i);
			conv_done_o <= 1'h0;
			conv_data_o <= ~raw;
			conv_chan_o <= ~ch;
		end
	endtask
endmodule
`default_nettype wire

// [tb_adc_result_buffer_formatter.sv]
// self-checking bench for the result buffer formatter
`default_nettype none
module tb_adc_result_buffer_formatter;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'h0, rst_i = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [3:0] strb = 4'hF;
	logic [31:0] wdata = 32'h0, got;
	logic [1:0] rsp;
	logic [11:0] raws [3] = '{12'h000, 12'h800, 12'hFFF};
	wire awready, wready, bvalid, arready, rvalid, done, on, flag, half;
	wire [1:0] bresp, rresp;
	wire [11:0] cdata;
	wire [4:0] cchan;
	wire [31:0] rd_w;
	int miscompares = 0, n_tests = 0, i, f, k;
	abrfmt_buffer DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rd_w), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conv_done_i(done), .conv_data_i(cdata),
		.conv_chan_i(cchan), .converter_on_o(on), .conversion_interrupt_flag_o(flag),
		.fill_half_status_o(half));
	abrfmt_conv_model CM (.sys_clk_i(sys_clk_i), .conv_done_o(done),
		.conv_data_o(cdata), .conv_chan_o(cchan));
	// 125 MHz
	initial forever #4 sys_clk_i = ~sys_clk_i;
	// expected stored word, 12-bit codes
	function automatic logic [15:0] fmt(input logic [1:0] fm, input logic [11:0] r);
		case (fm)
			2'h0: fmt = {4'h0, r};
			2'h1: fmt = {4'h0, r} - 16'h0800;
			2'h2: fmt = {r, 4'h0};
			default: fmt = {r, 4'h0} ^ 16'h8000;
		endcase
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		begin
			n_tests++;
			if (g !== e) begin
				miscompares++;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic bv;
		begin
			bv = 1'h0;
			@(posedge sys_clk_i);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			while (!bv) begin
				@(posedge sys_clk_i);
				if (awready) awvalid <= 1'h0;
				if (wready) wvalid <= 1'h0;
				bv = bvalid;
				rsp = bresp;
			end
			bready <= 1'h0;
			chk({30'h0, rsp}, {30'h0, er});
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic rv;
		begin
			rv = 1'h0;
			@(posedge sys_clk_i);
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			while (!rv) begin
				@(posedge sys_clk_i);
				if (arready) arvalid <= 1'h0;
				rv = rvalid;
				got = rd_w;
				rsp = rresp;
			end
			rready <= 1'h0;
			chk(got, e);
			chk({30'h0, rsp}, {30'h0, er});
		end
	endtask
	task automatic tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0) begin
				$display("Testbench passed");
			end else begin
				$display("Testbench failed");
			end
			$finish;
		end
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		wr(8'h04, 32'h0, 2'h0);
		for (f = 0; f < 4; f++) begin
			wr(8'h00, 32'h8000 | (f << 8), 2'h0);
			for (k = 0; k < 3; k++) begin
				CM.conv(k[4:0] + 5'h2, raws[k]);
				rd(8'h40, {16'h0, fmt(f[1:0], raws[k])}, 2'h0);
			end
		end
		// 10-bit codes in all four formats
		wr(8'h00, 32'h8400, 2'h0);
		CM.conv(5'h00, 12'h201);
		rd(8'h40, 32'h0201, 2'h0);
		wr(8'h00, 32'h8500, 2'h0);
		CM.conv(5'h00, 12'h201);
		rd(8'h40, 32'h0001, 2'h0);
		wr(8'h00, 32'h8700, 2'h0);
		CM.conv(5'h00, 12'h201);
		rd(8'h40, 32'h0040, 2'h0);
		wr(8'h00, 32'h8600, 2'h0);
		CM.conv(5'h00, 12'h201);
		rd(8'h40, 32'h8040, 2'h0);
		// off drops results, on again restarts at word zero
		wr(8'h00, 32'h0, 2'h0);
		chk({31'h0, on}, 32'h0);
		CM.conv(5'h00, 12'hFFF);
		rd(8'h40, 32'h8040, 2'h0);
		wr(8'h00, 32'h8000, 2'h0);
		chk({31'h0, on}, 32'h1);
		// control-one fields live in lane one; a lane-zero write leaves them
		strb <= 4'h1;
		wr(8'h00, 32'h0, 2'h0);
		strb <= 4'hF;
		rd(8'h00, 32'h8000, 2'h0);
		wr(8'h04, 32'h3C, 2'h0);
		wr(8'h0C, 32'h1, 2'h0);
		// look once the edge that takes the result has settled
		for (i = 0; i < 16; i++) begin
			CM.conv(5'h01, 12'(i));
			#1;
			chk({31'h0, flag}, {31'h0, i == 15});
		end
		rd(8'h0C, 32'h1, 2'h0);
		for (i = 0; i < 16; i++) rd(8'h40 + 8'(4 * i), 32'(i), 2'h0);
		CM.conv(5'h01, 12'h123);
		rd(8'h40, 32'h123, 2'h0);
		rd(8'h44, 32'h1, 2'h0);
		// split halves, two results a group
		wr(8'h04, 32'h6, 2'h0);
		chk({31'h0, half}, 32'h0);
		for (i = 0; i < 3; i++) CM.conv(5'h02, 12'hA0 + 12'(i));
		rd(8'h40, 32'hA0, 2'h0);
		rd(8'h44, 32'hA1, 2'h0);
		rd(8'h60, 32'hA2, 2'h0);
		rd(8'h04, 32'h86, 2'h0);
		chk({31'h0, half}, 32'h1);
		// channel placement, repeats overwrite
		wr(8'h04, 32'h83C, 2'h0);
		CM.conv(5'h05, 12'h111);
		CM.conv(5'h05, 12'h222);
		CM.conv(5'h03, 12'h333);
		rd(8'h54, 32'h222, 2'h0);
		rd(8'h4C, 32'h333, 2'h0);
		wr(8'h08, 32'h4, 2'h0);
		CM.conv(5'h03, 12'h777);
		rd(8'h4C, 32'h333, 2'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
